// ===== logic/tcr_pkg.sv
/*
  Shared constants, register layout and carrier types of the translation
  context router. Assumes a 32-bit APB register bus and 48-bit addresses.
*/
package tcr_pkg;

  localparam int ADDR_W = 48;
  localparam int ATTR_W = 8;
  localparam int SID_W = 8;
  localparam int NUM_GRP = 4;
  localparam int NUM_CB = 4;
  localparam int CB_W = 2;

  // Output address size in bits; address bits above it are cut on bypass
  localparam logic [7:0] OAS_BITS = 8'h28;

  // Register byte offsets
  localparam logic [11:0] OFF_GCFG = 12'h000;
  localparam logic [11:0] OFF_SCFG = 12'h004;
  localparam logic [11:0] OFF_OAS = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_COUNT = 12'h010;
  localparam logic [11:0] OFF_SMT = 12'h020;
  localparam logic [11:0] OFF_S2C = 12'h030;
  localparam logic [11:0] OFF_CBAR = 12'h040;
  localparam logic [11:0] OFF_SCTLR = 12'h050;
  localparam logic [11:0] OFF_BANK_MASK = 12'hFF0;
  localparam logic [1:0] IDX_LSB = 2'h2;

  // Field positions
  localparam int GCFG_CPD = 0;
  localparam int GCFG_USF = 1;
  localparam int GCFG_MMF = 2;
  localparam int GCFG_ATTR = 8;
  localparam int SCFG_SIF = 0;
  localparam int SMT_ID = 0;
  localparam int SMT_MASK = 8;
  localparam int SMT_VALID = 31;
  localparam int S2C_TYPE = 0;
  localparam int S2C_CB = 4;
  localparam int S2C_REPL = 7;
  localparam int S2C_ATTR = 8;
  localparam int CBAR_TYPE = 0;
  localparam int CBAR_S2CB = 4;
  localparam int CBAR_VALID = 7;
  localparam int CBAR_XFORM = 8;
  localparam int SCTLR_M = 0;
  localparam int SCTLR_ATTR = 8;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Stream-to-context entry types
  localparam logic [1:0] S2C_T_XLATE = 2'h0;
  localparam logic [1:0] S2C_T_BYPASS = 2'h1;
  localparam logic [1:0] S2C_T_FAULT = 2'h2;

  // Context bank types
  localparam logic [1:0] CB_T_S2 = 2'h0;
  localparam logic [1:0] CB_T_S1_BYP = 2'h1;
  localparam logic [1:0] CB_T_NEST = 2'h2;

  // Attribute layout: [3:0] memory type (lower is stricter), [7:4] flags
  localparam int ATTR_MT_HI = 3;

  typedef enum logic [3:0] {
    TCR_OC_NONE, TCR_OC_BYPASS, TCR_OC_XLATE, TCR_OC_F_UNID,
    TCR_OC_F_CONFLICT, TCR_OC_F_UNIMPL, TCR_OC_F_LOOKUP,
    TCR_OC_F_FETCH, TCR_OC_F_S2C
  } tcr_outcome_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ATTR_W-1:0] attr;
    logic [SID_W-1:0] sid;
    logic secure;
    logic ifetch;
  } tcr_txn_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ATTR_W-1:0] attr;
  } tcr_res_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CB_W-1:0] cb;
    logic stage2;
    logic nested;
    logic [CB_W-1:0] s2cb;
  } tcr_look_t;

  // Combine two attribute sets: stricter memory type, union of flags
  function automatic logic [ATTR_W-1:0] tcr_merge(
    input logic [ATTR_W-1:0] a,
    input logic [ATTR_W-1:0] b
  );
    logic [ATTR_W-1:0] r;
    r = a | b;
    r[ATTR_MT_HI:0] = (a[ATTR_MT_HI:0] < b[ATTR_MT_HI:0]) ?
      a[ATTR_MT_HI:0] : b[ATTR_MT_HI:0];
    return r;
  endfunction

endpackage

// ===== logic/tcr_lookup.sv
/*
  One translation lookup: TLB first, table walk only on a miss.
  Assumes the TLB and walker answer with a one-cycle valid each, and that
  the walker itself routes nested walk addresses through stage 2.
*/
`timescale 1ns/1ns
module tcr_lookup
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire tcr_look_t look,
  output logic done,
  output logic fault,
  output tcr_res_t res,
  output logic tlb_req,
  output tcr_look_t tlb_look,
  input wire logic tlb_rsp_valid,
  input wire logic tlb_rsp_hit,
  input wire tcr_res_t tlb_rsp,
  output logic walk_req,
  output tcr_look_t walk_look,
  input wire logic walk_rsp_valid,
  input wire logic walk_rsp_fault,
  input wire tcr_res_t walk_rsp
);

  typedef enum logic [1:0] {L_IDLE, L_TLB, L_WALK} tcr_lstate_t;

  tcr_lstate_t state_reg;
  tcr_look_t look_reg;
  logic done_reg;
  logic fault_reg;
  tcr_res_t res_reg;

  assign tlb_req = (state_reg == L_TLB);
  assign walk_req = (state_reg == L_WALK);
  assign tlb_look = look_reg;
  // Walk of a nested stage 1 carries the stage 2 bank for its addresses
  assign walk_look = look_reg;
  assign done = done_reg;
  assign fault = fault_reg;
  assign res = res_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= L_IDLE;
      look_reg <= '0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      res_reg <= '0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        L_IDLE:
        begin
          if (start)
          begin
            look_reg <= look;
            state_reg <= L_TLB;
          end
        end
        L_TLB:
        begin
          if (tlb_rsp_valid && tlb_rsp_hit)
          begin
            res_reg <= tlb_rsp;
            fault_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= L_IDLE;
          end
          else if (tlb_rsp_valid)
            state_reg <= L_WALK;
        end
        L_WALK:
        begin
          if (walk_rsp_valid)
          begin
            res_reg <= walk_rsp;
            fault_reg <= walk_rsp_fault;
            done_reg <= 1'b1;
            state_reg <= L_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ===== logic/tcr_router.sv
/*
  Translation context router: per-transaction choice of bypass, fault or a
  path through one or two context banks, with its APB register file.
  Assumes one transaction in flight, external TLB and table walker.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module tcr_router
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic up_valid,
  output logic up_ready,
  input wire tcr_txn_t up_txn,
  output logic up_err_valid,
  input wire logic up_err_ready,
  output logic dn_valid,
  input wire logic dn_ready,
  output tcr_res_t dn_res,
  output logic tlb_req,
  output tcr_look_t tlb_look,
  input wire logic tlb_rsp_valid,
  input wire logic tlb_rsp_hit,
  input wire tcr_res_t tlb_rsp,
  output logic walk_req,
  output tcr_look_t walk_look,
  input wire logic walk_rsp_valid,
  input wire logic walk_rsp_fault,
  input wire tcr_res_t walk_rsp
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DECIDE, ST_S1, ST_S2, ST_OUT, ST_ERR
  } tcr_state_t;

  function automatic logic bank_hit(
    input logic [11:0] a,
    input logic [11:0] base,
    input int idx
  );
    return ((a & OFF_BANK_MASK) == base) &&
      (a[3:2] == idx[1:0]);
  endfunction

  logic [31:0] gcfg_reg;
  logic [31:0] scfg_reg;
  logic [31:0] smt_reg [NUM_GRP];
  logic [31:0] s2c_reg [NUM_GRP];
  logic [31:0] cbar_reg [NUM_CB];
  logic [31:0] sctlr_reg [NUM_CB];
  logic [15:0] xlate_cnt_reg;
  logic [15:0] fault_cnt_reg;
  tcr_outcome_t outcome_reg;

  tcr_state_t state_reg;
  tcr_txn_t txn_reg;
  tcr_res_t cur_reg;
  logic [CB_W-1:0] s1cb_reg;
  logic [CB_W-1:0] s2cb_reg;
  logic do_s2_reg;
  logic nested_reg;
  logic xform_en_reg;
  logic [ATTR_W-1:0] xform_reg;
  logic launched_reg;

  wire logic wr_en = psel && penable && pwrite;
  wire logic [1:0] reg_idx = paddr[IDX_LSB +: 2];
  wire logic cpd = gcfg_reg[GCFG_CPD];
  wire logic usf_fault = gcfg_reg[GCFG_USF];
  wire logic mmf_fault = gcfg_reg[GCFG_MMF];
  wire logic [ATTR_W-1:0] g_attr = gcfg_reg[GCFG_ATTR +: ATTR_W];
  wire logic sif_en = scfg_reg[SCFG_SIF];

  // Stream matching
  logic [NUM_GRP-1:0] match_vec;
  logic [CB_W-1:0] match_idx;
  logic [2:0] match_cnt;
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++)
    begin : gen_match
      assign match_vec[g] = smt_reg[g][SMT_VALID] &&
        (((txn_reg.sid ^ smt_reg[g][SMT_ID +: SID_W]) &
        ~smt_reg[g][SMT_MASK +: SID_W]) == '0);
    end
  endgenerate

  always_comb
  begin
    match_cnt = 3'h0;
    match_idx = '0;
    for (int i = 0; i < NUM_GRP; i++)
    begin
      match_cnt = match_cnt + {2'h0, match_vec[i]};
      if (match_vec[i])
        match_idx = CB_W'(i);
    end
  end

  // Fields of the selected entries
  wire logic [31:0] s2c = s2c_reg[match_idx];
  wire logic [1:0] s2c_type = s2c[S2C_TYPE +: 2];
  wire logic [CB_W-1:0] s2c_cb = s2c[S2C_CB +: CB_W];
  wire logic [ATTR_W-1:0] s2c_attr = s2c[S2C_ATTR +: ATTR_W];
  wire logic [ATTR_W-1:0] in_attr = s2c[S2C_REPL] ? s2c_attr :
    txn_reg.attr;
  wire logic [31:0] cbar = cbar_reg[s2c_cb];
  wire logic [1:0] cb_type = cbar[CBAR_TYPE +: 2];
  wire logic cb_valid = cbar[CBAR_VALID];
  wire logic [CB_W-1:0] cb_s2 = cbar[CBAR_S2CB +: CB_W];
  wire logic s2_valid = cbar_reg[cb_s2][CBAR_VALID];
  wire logic [ATTR_W-1:0] cb_xform = cbar[CBAR_XFORM +: ATTR_W];

  // Stage enables for the current stage
  wire logic [CB_W-1:0] stage_cb = (state_reg == ST_S1) ? s1cb_reg :
    s2cb_reg;
  wire logic stage_m = sctlr_reg[stage_cb][SCTLR_M];
  wire logic [ATTR_W-1:0] stage_attr =
    sctlr_reg[stage_cb][SCTLR_ATTR +: ATTR_W];

  // Addresses above the output size read as zero on early bypass
  wire logic [ADDR_W-1:0] oas_mask = ~({ADDR_W{1'b1}} << OAS_BITS);
  wire logic [ADDR_W-1:0] byp_addr = txn_reg.addr & oas_mask;

  wire logic fetch_fail = sif_en && txn_reg.secure && txn_reg.ifetch;

  logic look_start;
  logic look_done;
  logic look_fault;
  tcr_res_t look_res;
  tcr_look_t look_in;

  assign look_start = ((state_reg == ST_S1) || (state_reg == ST_S2)) &&
    stage_m && !launched_reg;
  assign look_in.addr = cur_reg.addr;
  assign look_in.cb = stage_cb;
  assign look_in.stage2 = (state_reg == ST_S2);
  assign look_in.nested = nested_reg && (state_reg == ST_S1);
  assign look_in.s2cb = s2cb_reg;

  tcr_lookup u_lookup (
    .pclk(pclk),
    .presetn(presetn),
    .start(look_start),
    .look(look_in),
    .done(look_done),
    .fault(look_fault),
    .res(look_res),
    .tlb_req(tlb_req),
    .tlb_look(tlb_look),
    .tlb_rsp_valid(tlb_rsp_valid),
    .tlb_rsp_hit(tlb_rsp_hit),
    .tlb_rsp(tlb_rsp),
    .walk_req(walk_req),
    .walk_look(walk_look),
    .walk_rsp_valid(walk_rsp_valid),
    .walk_rsp_fault(walk_rsp_fault),
    .walk_rsp(walk_rsp)
  );

  // Result of the stage in progress: lookup or control attributes
  wire logic stage_ok = !stage_m || look_done;
  wire tcr_res_t stage_res = stage_m ? look_res :
    '{addr: cur_reg.addr, attr: tcr_merge(cur_reg.attr, stage_attr)};
  wire logic stage_fault = stage_m && look_done && look_fault;

  assign up_ready = (state_reg == ST_IDLE);
  assign dn_valid = (state_reg == ST_OUT);
  assign dn_res = cur_reg;
  assign up_err_valid = (state_reg == ST_ERR);
  logic addr_ok;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    addr_ok = 1'b1;
    prdata = RST_ZERO;
    unique case (paddr & OFF_BANK_MASK)
      OFF_GCFG:
      begin
        unique case (paddr)
          OFF_GCFG: prdata = gcfg_reg;
          OFF_SCFG: prdata = scfg_reg;
          OFF_OAS: prdata = {24'h0, OAS_BITS};
          OFF_STATUS: prdata = {28'h0, outcome_reg};
          default: addr_ok = 1'b0;
        endcase
      end
      OFF_COUNT:
      begin
        if (paddr == OFF_COUNT)
          prdata = {fault_cnt_reg, xlate_cnt_reg};
        else
          addr_ok = 1'b0;
      end
      // One word per bank entry; the low address bits pick the entry
      OFF_SMT: prdata = smt_reg[reg_idx];
      OFF_S2C: prdata = s2c_reg[reg_idx];
      OFF_CBAR: prdata = cbar_reg[reg_idx];
      OFF_SCTLR: prdata = sctlr_reg[reg_idx];
      default: addr_ok = 1'b0;
    endcase
  end

  // Register writes; a write takes effect in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gcfg_reg <= RST_ZERO;
      scfg_reg <= RST_ZERO;
    end
    else if (wr_en && (paddr == OFF_GCFG))
      gcfg_reg <= pwdata;
    else if (wr_en && (paddr == OFF_SCFG))
      scfg_reg <= pwdata;
  end

  generate
    for (g = 0; g < NUM_GRP; g++)
    begin : gen_regs
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          smt_reg[g] <= RST_ZERO;
          s2c_reg[g] <= RST_ZERO;
          cbar_reg[g] <= RST_ZERO;
          sctlr_reg[g] <= RST_ZERO;
        end
        else if (wr_en)
        begin
          if (bank_hit(paddr, OFF_SMT, g))
            smt_reg[g] <= pwdata;
          if (bank_hit(paddr, OFF_S2C, g))
            s2c_reg[g] <= pwdata;
          if (bank_hit(paddr, OFF_CBAR, g))
            cbar_reg[g] <= pwdata;
          if (bank_hit(paddr, OFF_SCTLR, g))
            sctlr_reg[g] <= pwdata;
        end
      end
    end
  endgenerate

  // Decision faults and bypass are finished in the decision cycle, lookup faults in ST_S1 or ST_S2; order is fixed
  task automatic finish_fault(input tcr_outcome_t oc);
    outcome_reg <= oc;
    state_reg <= ST_ERR;
  endtask

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      txn_reg <= '0;
      cur_reg <= '0;
      s1cb_reg <= '0;
      s2cb_reg <= '0;
      do_s2_reg <= 1'b0;
      nested_reg <= 1'b0;
      xform_en_reg <= 1'b0;
      xform_reg <= '0;
      launched_reg <= 1'b0;
      outcome_reg <= TCR_OC_NONE;
      xlate_cnt_reg <= '0;
      fault_cnt_reg <= '0;
    end
    else
    begin
      if (look_start)
        launched_reg <= 1'b1;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (up_valid)
          begin
            txn_reg <= up_txn;
            state_reg <= ST_DECIDE;
          end
        end
        ST_DECIDE:
        begin
          if (cpd && fetch_fail)
            finish_fault(TCR_OC_F_FETCH);
          else if (cpd)
          begin
            cur_reg <= '{addr: byp_addr,
              attr: tcr_merge(txn_reg.attr, g_attr)};
            outcome_reg <= TCR_OC_BYPASS;
            state_reg <= ST_OUT;
          end
          else if ((match_cnt == 3'h0 && usf_fault) ||
            (match_cnt > 3'h1 && mmf_fault))
            finish_fault((match_cnt == 3'h0) ? TCR_OC_F_UNID :
              TCR_OC_F_CONFLICT);
          else if (match_cnt != 3'h1)
          begin
            cur_reg <= '{addr: byp_addr,
              attr: tcr_merge(txn_reg.attr, g_attr)};
            outcome_reg <= TCR_OC_BYPASS;
            state_reg <= ST_OUT;
          end
          else if (s2c_type == S2C_T_BYPASS)
          begin
            cur_reg <= '{addr: byp_addr,
              attr: tcr_merge(txn_reg.attr, s2c_attr)};
            outcome_reg <= TCR_OC_BYPASS;
            state_reg <= ST_OUT;
          end
          else if (s2c_type != S2C_T_XLATE)
            finish_fault(TCR_OC_F_S2C);
          else if (!cb_valid ||
            (cb_type == CB_T_NEST && !s2_valid))
            finish_fault(TCR_OC_F_UNIMPL);
          else
          begin
            // Stage 2 only treats the input attributes as stage 1 output
            cur_reg <= '{addr: txn_reg.addr, attr: in_attr};
            s1cb_reg <= s2c_cb;
            s2cb_reg <= (cb_type == CB_T_NEST) ? cb_s2 : s2c_cb;
            do_s2_reg <= (cb_type != CB_T_S1_BYP);
            nested_reg <= (cb_type == CB_T_NEST);
            xform_en_reg <= (cb_type == CB_T_S1_BYP);
            xform_reg <= cb_xform;
            state_reg <= (cb_type == CB_T_S2) ? ST_S2 : ST_S1;
          end
        end
        ST_S1:
        begin
          if (stage_fault)
          begin
            launched_reg <= 1'b0;
            finish_fault(TCR_OC_F_LOOKUP);
          end
          else if (stage_ok)
          begin
            launched_reg <= 1'b0;
            cur_reg <= stage_res;
            if (xform_en_reg)
              cur_reg.attr <= tcr_merge(stage_res.attr, xform_reg);
            outcome_reg <= TCR_OC_XLATE;
            state_reg <= do_s2_reg ? ST_S2 : ST_OUT;
          end
        end
        ST_S2:
        begin
          if (stage_fault)
          begin
            launched_reg <= 1'b0;
            finish_fault(TCR_OC_F_LOOKUP);
          end
          else if (stage_ok)
          begin
            launched_reg <= 1'b0;
            cur_reg.addr <= stage_res.addr;
            cur_reg.attr <= tcr_merge(cur_reg.attr,
              stage_res.attr);
            outcome_reg <= TCR_OC_XLATE;
            state_reg <= ST_OUT;
          end
        end
        ST_OUT:
        begin
          if (dn_ready)
          begin
            xlate_cnt_reg <= xlate_cnt_reg + CNT_ONE;
            state_reg <= ST_IDLE;
          end
        end
        ST_ERR:
        begin
          if (up_err_ready)
          begin
            fault_cnt_reg <= fault_cnt_reg + CNT_ONE;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== test/tcr_router_monitor.sv
/*
  Port checker for tcr_router, bound to every instance of it.
  Assumes one pclk domain and presetn low clears all state.
*/
`timescale 1ns/1ns
module tcr_router_monitor
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic up_err_valid,
  input wire logic up_err_ready,
  input wire logic dn_valid,
  input wire logic dn_ready,
  input wire tcr_res_t dn_res,
  input wire logic tlb_req,
  input wire logic tlb_rsp_valid,
  input wire logic tlb_rsp_hit,
  input wire logic walk_req
);
  default clocking mon_ck @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  unmapped_err_a: assert property (psel && penable && paddr[11:7] != 5'h00
    |-> pslverr) else $error("unmapped access without slave error");
  one_answer_a: assert property (!(dn_valid && up_err_valid))
    else $error("faulted transaction also forwarded");
  dn_hold_a: assert property (dn_valid && !dn_ready
    |=> dn_valid && $stable(dn_res)) else $error("result dropped early");
  err_hold_a: assert property (up_err_valid && !up_err_ready
    |=> up_err_valid) else $error("error response dropped early");
  busy_block_a: assert property (dn_valid || up_err_valid || tlb_req
    || walk_req |-> !up_ready) else $error("new client taken while busy");
  take_once_a: assert property (up_valid && up_ready
    |=> !up_ready ##1 !up_ready) else $error("ready too soon after take");
  answer_bound_a: assert property (up_valid && up_ready
    |-> ##[2:400] (dn_valid || up_err_valid)) else $error("no answer");
  tlb_wait_a: assert property (tlb_req && !tlb_rsp_valid
    |=> tlb_req) else $error("lookup dropped before answer");
  hit_no_walk_a: assert property (tlb_rsp_valid && tlb_rsp_hit
    |=> !walk_req [*3]) else $error("walk started on a hit");
  miss_walk_a: assert property (tlb_rsp_valid && !tlb_rsp_hit
    |-> ##[1:3] walk_req) else $error("no walk after a miss");

  cover property (dn_valid && dn_ready);
  cover property (up_err_valid && up_err_ready);
  cover property (walk_req);
endmodule

bind tcr_router tcr_router_monitor u_mon (.pclk, .presetn, .psel,
  .penable, .paddr, .pslverr, .up_valid, .up_ready, .up_err_valid,
  .up_err_ready, .dn_valid, .dn_ready, .dn_res, .tlb_req, .tlb_rsp_valid,
  .tlb_rsp_hit, .walk_req);

// ===== test/tcr_far_model.sv
/*
  Far side of the router: TLB and table walker answering lookups.
  Assumes each request is held until its one-cycle answer.
*/
`timescale 1ns/1ns
module tcr_far_model
  import tcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] dly,
  input wire logic hit,
  input wire logic wfault,
  input wire logic tlb_req,
  input wire tcr_look_t tlb_look,
  output logic tlb_rsp_valid,
  output logic tlb_rsp_hit,
  output tcr_res_t tlb_rsp,
  input wire logic walk_req,
  input wire tcr_look_t walk_look,
  output logic walk_rsp_valid,
  output logic walk_rsp_fault,
  output tcr_res_t walk_rsp
);
  // Translated page sits at a fixed offset from the input address
  localparam logic [47:0] XOFF = 48'h0000_1000_0000;
  logic [1:0] tcnt_reg;
  logic [1:0] wcnt_reg;
  logic tdone_reg;
  logic wdone_reg;

  // Answer lines scramble between answers so stale data never passes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {tcnt_reg, wcnt_reg, tdone_reg, wdone_reg} <= '0;
      {tlb_rsp_valid, tlb_rsp_hit, tlb_rsp} <= '0;
      {walk_rsp_valid, walk_rsp_fault, walk_rsp} <= '0;
    end
    else
    begin
      tlb_rsp_valid <= 1'b0;
      walk_rsp_valid <= 1'b0;
      tlb_rsp <= ~tlb_rsp;
      walk_rsp <= ~walk_rsp;
      tlb_rsp_hit <= ~tlb_rsp_hit;
      walk_rsp_fault <= ~walk_rsp_fault;
      tdone_reg <= tlb_req && (tdone_reg || tcnt_reg == dly);
      wdone_reg <= walk_req && (wdone_reg || wcnt_reg == dly);
      tcnt_reg <= (tlb_req && !tdone_reg) ? tcnt_reg + 2'h1 : 2'h0;
      wcnt_reg <= (walk_req && !wdone_reg) ? wcnt_reg + 2'h1 : 2'h0;
      if (tlb_req && !tdone_reg && tcnt_reg == dly)
      begin
        tlb_rsp_valid <= 1'b1;
        tlb_rsp_hit <= hit;
        tlb_rsp <= '{tlb_look.addr + XOFF, 8'h07};
      end
      if (walk_req && !wdone_reg && wcnt_reg == dly)
      begin
        walk_rsp_valid <= 1'b1;
        walk_rsp_fault <= wfault;
        walk_rsp <= '{walk_look.addr + XOFF, 8'h07};
      end
    end
endmodule

// ===== test/translation_context_router_tb.sv
/*
  Self-checking bench for tcr_router: a table of bypass and fault cases ending in one stage 2 pass with translation off,
  then lookups, replacement attributes and invalid banks by hand.
  Assumes tcr_far_model stands in for the TLB and the walker.
*/
`timescale 1ns/1ns
module translation_context_router_tb
  import tcr_pkg::*;
;
  typedef struct packed {
    logic [15:0] gcfg;
    logic scfg;
    logic [7:0] sid;
    logic sec;
    logic ifx;
    logic hi;
    logic [7:0] attr;
    logic [7:0] oth;
    logic err;
  } tcr_row_t;
  localparam logic [39:0] BASE = 40'hAB_1234_5678;
  localparam logic [47:0] XOFF = 48'h0000_1000_0000;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rerr, hit, wfault;
  logic up_valid, up_ready, up_err_valid, up_err_ready, dn_valid, dn_ready;
  logic tlb_req, tlb_rsp_valid, tlb_rsp_hit, walk_req, walk_rsp_valid;
  logic walk_rsp_fault;
  logic [1:0] dly;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  tcr_txn_t up_txn;
  tcr_res_t dn_res, tlb_rsp, walk_rsp;
  tcr_look_t tlb_look, walk_look;
  tcr_row_t hr;
  int n_fail = 0;
  int total_checks = 0;
  logic [43:0] cfg [8] = '{
    {12'h020, 32'h8000_0010}, {12'h024, 32'h8000_0020},
    {12'h028, 32'h8000_0020}, {12'h02C, 32'h8000_0030},
    {12'h030, 32'h0000_3101}, {12'h03C, 32'h0000_0010},
    {12'h044, 32'h0000_0080}, {12'h054, 32'h0000_8200}};
  tcr_row_t rows [10] = '{
    '{16'h4201, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 8'h15, 8'h42, 1'b0},
    '{16'h4201, 1'b1, 8'h10, 1'b1, 1'b1, 1'b0, 8'h15, 8'h42, 1'b1},
    '{16'h4201, 1'b0, 8'h10, 1'b1, 1'b1, 1'b0, 8'h15, 8'h42, 1'b0},
    '{16'h4200, 1'b0, 8'h99, 1'b0, 1'b0, 1'b1, 8'h15, 8'h42, 1'b0},
    '{16'h4202, 1'b0, 8'h99, 1'b0, 1'b0, 1'b0, 8'h15, 8'h42, 1'b1},
    '{16'h4200, 1'b0, 8'h20, 1'b0, 1'b0, 1'b1, 8'h15, 8'h42, 1'b0},
    '{16'h4204, 1'b0, 8'h20, 1'b0, 1'b0, 1'b0, 8'h15, 8'h42, 1'b1},
    '{16'h4201, 1'b0, 8'h30, 1'b0, 1'b0, 1'b0, 8'h15, 8'h42, 1'b0},
    '{16'h4200, 1'b0, 8'h10, 1'b0, 1'b0, 1'b1, 8'h15, 8'h31, 1'b0},
    '{16'h4200, 1'b0, 8'h30, 1'b0, 1'b0, 1'b0, 8'h15, 8'h82, 1'b0}};

  tcr_router u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .up_valid, .up_ready, .up_txn,
    .up_err_valid, .up_err_ready, .dn_valid, .dn_ready, .dn_res, .tlb_req,
    .tlb_look, .tlb_rsp_valid, .tlb_rsp_hit, .tlb_rsp, .walk_req,
    .walk_look, .walk_rsp_valid, .walk_rsp_fault, .walk_rsp);
  tcr_far_model u_far (.pclk, .presetn, .dly, .hit, .wfault, .tlb_req,
    .tlb_look, .tlb_rsp_valid, .tlb_rsp_hit, .tlb_rsp, .walk_req,
    .walk_look, .walk_rsp_valid, .walk_rsp_fault, .walk_rsp);

  always #20 pclk = ~pclk;

  function automatic logic [7:0] mrg(input logic [7:0] a, input logic [7:0] b);
    mrg = a | b;
    mrg[3:0] = (a[3:0] < b[3:0]) ? a[3:0] : b[3:0];
  endfunction

  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lookup results are checked on address only: attribute mixing there
  // depends on the TLB and walker attributes, which tcr_far_model fixes at 8'h07
  task automatic run(input tcr_row_t r, input logic lk, input int st,
    input logic [7:0] ea);
    int n;
    @(posedge pclk);
    up_valid <= 1'b1;
    up_txn <= '{{r.hi ? 8'hFF : 8'h00, BASE}, r.attr, r.sid, r.sec, r.ifx};
    @(posedge pclk);
    while (up_ready !== 1'b1)
      @(posedge pclk);
    up_valid <= 1'b0;
    n = 0;
    while (dn_valid !== 1'b1 && up_err_valid !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk({up_err_valid, dn_valid}, r.err ? 2'h2 : 2'h1);
    if (!r.err && lk)
      chk(dn_res.addr, {8'h00, BASE} + XOFF);
    if (!r.err && !lk)
      chk(dn_res, {8'h00, BASE, ea});
    repeat (st) @(posedge pclk);
    dn_ready <= 1'b1;
    up_err_ready <= 1'b1;
    @(posedge pclk);
    dn_ready <= 1'b0;
    up_err_ready <= 1'b0;
  endtask

  initial
  begin
    #2000000;
    n_fail++;
    finish_test;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {up_valid, up_txn, dn_ready, up_err_ready, dly, wfault} = '0;
    hit = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({up_ready, dn_valid, up_err_valid, tlb_req, walk_req}, 5'h10);
    apb(1'b0, OFF_OAS, 32'h0000_0000);
    chk(rdat, {24'h00_0000, OAS_BITS});
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({rerr, rdat}, {1'b1, 32'h0000_0000});
    foreach (cfg[i])
      apb(1'b1, cfg[i][43:32], cfg[i][31:0]);
    apb(1'b0, 12'h02C, 32'h0000_0000);
    chk(rdat, 32'h8000_0030);
    foreach (rows[i])
    begin
      apb(1'b1, OFF_GCFG, {16'h0000, rows[i].gcfg});
      apb(1'b1, OFF_SCFG, {31'h0000_0000, rows[i].scfg});
      run(rows[i], 1'b0, i % 3, mrg(rows[i].attr, rows[i].oth));
    end
    hr = rows[9];
    apb(1'b1, 12'h054, 32'h0000_8201);
    dly <= 2'h3;
    run(hr, 1'b1, 3, 8'h00);
    hit <= 1'b0;
    dly <= 2'h0;
    run(hr, 1'b1, 0, 8'h00);
    wfault <= 1'b1;
    hr.err = 1'b1;
    run(hr, 1'b1, 2, 8'h00);
    wfault <= 1'b0;
    hr.err = 1'b0;
    apb(1'b1, 12'h054, 32'h0000_8200);
    apb(1'b1, 12'h03C, 32'h0000_5590);
    run(hr, 1'b0, 0, mrg(8'h55, 8'h82));
    apb(1'b1, 12'h044, 32'h0000_3381);
    run(hr, 1'b0, 0, mrg(mrg(8'h55, 8'h82), 8'h33));
    apb(1'b1, 12'h044, 32'h0000_0092);
    run(hr, 1'b0, 0, mrg(mrg(8'h55, 8'h82), 8'h82));
    hr.err = 1'b1;
    apb(1'b1, 12'h044, 32'h0000_0000);
    run(hr, 1'b0, 1, 8'h00);
    apb(1'b1, 12'h044, 32'h0000_0001);
    run(hr, 1'b0, 0, 8'h00);
    apb(1'b0, OFF_COUNT, 32'h0000_0000);
    chk(rdat, 32'h0006_000C);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rdat, {28'h000_0000, TCR_OC_F_UNIMPL});
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_COUNT, 32'h0000_0000);
    chk({rerr, rdat}, 33'h0_0000_0000);
    finish_test;
  end
endmodule
